// ===== rtl/rcsp_port.sv
// Three-wire configuration serial port with register bank and recovered bit clock.
// What this block does
// (RULE1) Write: direction, A1 A0, D7..D0 sampled rising.
// (RULE2) Read: direction and A1 A0 sampled rising.
// (RULE3) Read data driven D7 first at rising.
// (RULE4) Host samples read data on falling edge.
// (RULE5) Further write bytes increment address, wrap 2->0.
// (RULE6) External recovery receive: both registers zero.
// (RULE7) Internal recovery: first 01, second 04 hex.
// (RULE8) Transmit 40/20 hex, sleep 80/00 hex.
// (RULE9) Select high for whole transfer; else ignored.
// (RULE10) First select rise enters serial control permanently.
// (RULE11) Select rise wakes device from sleep.
// (RULE12) Bit clock runs from start until bit0 cleared.
`timescale 1ns/1ps
module rcsp_port
  import rcsp_pkg::*;
#(
  parameter int RECOV_HALF_CYC = RCSP_RECOV_HALF_CYC
) (
  // Clock, reset and enable.
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  // Serial pins from the host.
  input wire logic select_pin,
  input wire logic config_serial_clock,
  input wire logic config_serial_data_in,
  output logic config_serial_data_out,
  output logic config_serial_data_oe,
  // Receiver side.
  input wire logic start_symbol,
  output logic recovered_bit_clock,
  // Control outputs to the radio.
  output rcsp_ctrl_t ctrl
);

  // Refuse a half period that the bit clock counter cannot hold.
  if (RECOV_HALF_CYC < 1 || RECOV_HALF_CYC >= (1 << RCSP_CNT_W)) begin : g_bad_half
    $error("RECOV_HALF_CYC out of range");
  end

  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic sel_d_r;
  logic clk_d_r;
  rcsp_pins_t pins;
  logic sel_rise;
  logic clk_rise;
  logic clk_fall;
  rcsp_state_t state_r;
  logic dir_r;
  logic [1:0] addr_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] regs_r [RCSP_NUM_REGS];
  logic serial_r;
  logic active_r;
  logic drive_r;
  logic dout_r;
  logic [7:0] rd_cur;
  logic recov_run_r;
  logic [RCSP_CNT_W-1:0] recov_cnt_r;
  logic recov_clk_r;

  // Next address with wrap from the last register back to the first.
  function automatic logic [1:0] next_addr(input logic [1:0] a);
    next_addr = (a == RCSP_ADDR_LAST) ? RCSP_ADDR_FIRST : a + 2'h1;
  endfunction

  // Read mux; an address past the bank reads as zero.
  function automatic logic [7:0] read_reg(input logic [1:0] a);
    read_reg = (a <= RCSP_ADDR_LAST) ? regs_r[a] : RCSP_REG_RESET;
  endfunction

  // Two-flop synchronisers for the pins, the host clock included.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else if (clk_en) begin
      sync1_r <= {select_pin, config_serial_clock, config_serial_data_in};
      sync2_r <= sync1_r;
    end
  end

  assign pins = rcsp_pins_t'(sync2_r);

  // Edge history of the synchronised select and serial clock.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sel_d_r <= 1'b0;
      clk_d_r <= 1'b0;
    end else if (clk_en) begin
      sel_d_r <= pins.select;
      clk_d_r <= pins.sclk;
    end
  end

  assign sel_rise = pins.select & ~sel_d_r;
  // Serial clock edges only count while select is high.
  assign clk_rise = pins.select & pins.sclk & ~clk_d_r; // RULE9
  assign clk_fall = pins.select & ~pins.sclk & clk_d_r;

  // Mode latches: serial control is sticky; select rise wakes the radio.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      serial_r <= 1'b0;
      active_r <= 1'b0;
    end else if (clk_en) begin
      if (sel_rise) begin
        serial_r <= 1'b1; // RULE10
        active_r <= 1'b1; // RULE11
      end else if (clk_rise && state_r == RCSP_ST_DATA && dir_r == RCSP_DIR_WRITE &&
                   bit_cnt_r == 3'h7 && addr_r == RCSP_ADDR_FIRST) begin
        // A write to the first register decides sleep from its top bit.
        // The new byte's top bit still sits one place down in the shifter.
        active_r <= ~shift_r[RCSP_SLEEP_BIT - 1]; // RULE8
      end
    end
  end

  // Transfer sequencer: direction, two address bits, then data groups.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= RCSP_ST_DIR;
      dir_r <= RCSP_DIR_WRITE;
      addr_r <= 2'h0;
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
    end else if (clk_en) begin
      if (!pins.select) begin
        // Dropping select abandons any partial byte.
        state_r <= RCSP_ST_DIR; // RULE9
        bit_cnt_r <= 3'h0;
      end else if (clk_rise) begin
        case (state_r)
          RCSP_ST_DIR: begin
            dir_r <= pins.sdata; // RULE1 RULE2
            state_r <= RCSP_ST_ADDR;
            bit_cnt_r <= 3'h0;
          end
          RCSP_ST_ADDR: begin
            addr_r <= {addr_r[0], pins.sdata}; // RULE2
            if (bit_cnt_r == 3'h1) begin
              state_r <= RCSP_ST_DATA;
              bit_cnt_r <= 3'h0;
            end else begin
              bit_cnt_r <= bit_cnt_r + 3'h1;
            end
          end
          RCSP_ST_DATA: begin
            shift_r <= {shift_r[6:0], pins.sdata}; // RULE1
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
              addr_r <= next_addr(addr_r); // RULE5
            end
          end
          default: begin
            state_r <= RCSP_ST_DIR;
          end
        endcase
      end
    end
  end

  // Register bank: a write lands each time eight data bits are complete at an address in the bank.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < RCSP_NUM_REGS; i++) begin
        regs_r[i] <= RCSP_REG_RESET;
      end
    end else if (clk_en) begin
      if (clk_rise && state_r == RCSP_ST_DATA && dir_r == RCSP_DIR_WRITE &&
          bit_cnt_r == 3'h7 && addr_r <= RCSP_ADDR_LAST) begin
        regs_r[addr_r] <= {shift_r[6:0], pins.sdata}; // RULE1 RULE6 RULE7
      end
    end
  end

  // Register addressed by the current transfer, for the read shifter.
  assign rd_cur = read_reg(addr_r);

  // Read data launch on each rising edge of the data phase, MSB first.
  // The line stays driven after D0 so the host can take it on the last fall.
  // Only dropping select frees it, which keeps the turnaround in the host's hands.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      drive_r <= 1'b0;
      dout_r <= 1'b0;
    end else if (clk_en) begin
      if (!pins.select) begin
        drive_r <= 1'b0;
        dout_r <= 1'b0;
      end else if (clk_rise && state_r == RCSP_ST_DATA && dir_r == RCSP_DIR_READ) begin
        // Bit index counts down from D7 at the first data rise; host samples on fall.
        drive_r <= 1'b1; // RULE3
        dout_r <= rd_cur[3'h7 - bit_cnt_r]; // RULE3 RULE4
      end
    end
  end

  assign config_serial_data_out = dout_r;
  assign config_serial_data_oe = drive_r;

  // Recovered bit clock: starts on a start symbol, stops when bit 0 clears.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      recov_run_r <= 1'b0;
      recov_cnt_r <= '0;
      recov_clk_r <= 1'b0;
    end else if (clk_en) begin
      if (!regs_r[RCSP_ADDR_FIRST][RCSP_RECOVERY_EN_BIT]) begin
        recov_run_r <= 1'b0; // RULE12
        recov_cnt_r <= '0;
        recov_clk_r <= 1'b0;
      end else if (!recov_run_r) begin
        recov_run_r <= start_symbol; // RULE12
      end else if (recov_cnt_r == RCSP_CNT_W'(RECOV_HALF_CYC - 1)) begin
        recov_cnt_r <= '0;
        recov_clk_r <= ~recov_clk_r;
      end else begin
        recov_cnt_r <= recov_cnt_r + RCSP_CNT_W'(1);
      end
    end
  end

  assign recovered_bit_clock = recov_clk_r;

  // Control outputs.
  assign ctrl.first_config_register = regs_r[RCSP_ADDR_FIRST];
  assign ctrl.second_config_register = regs_r[RCSP_ADDR_SECOND];
  assign ctrl.third_config_register = regs_r[RCSP_ADDR_LAST];
  assign ctrl.serial_control = serial_r;
  assign ctrl.active_mode = active_r;

endmodule

// ===== rtl/rcsp_pkg.sv
// Package of constants and carrier types for the radio configuration serial port.
package rcsp_pkg;

  // Register bank layout.
  localparam int RCSP_ADDR_W = 2;
  localparam int RCSP_DATA_W = 8;
  localparam int RCSP_NUM_REGS = 3;
  localparam logic [1:0] RCSP_ADDR_FIRST = 2'h0;
  localparam logic [1:0] RCSP_ADDR_SECOND = 2'h1;
  localparam logic [1:0] RCSP_ADDR_LAST = 2'h2;
  localparam logic [7:0] RCSP_REG_RESET = 8'h00;

  // Field positions in the first configuration register.
  localparam int RCSP_RECOVERY_EN_BIT = 0;
  localparam int RCSP_SLEEP_BIT = 7;
  localparam int RCSP_TX_BIT = 6;

  // Direction bit values as shifted in first.
  localparam logic RCSP_DIR_READ = 1'b1;
  localparam logic RCSP_DIR_WRITE = 1'b0;

  // Recovered bit clock half period, 19.2 kb/s at 200 MHz.
  localparam int RCSP_CLK_MHZ = 200;
  localparam int RCSP_BIT_RATE_BPS = 19200;
  localparam int RCSP_RECOV_HALF_CYC =
    (RCSP_CLK_MHZ * 1000000) / (2 * RCSP_BIT_RATE_BPS);
  localparam int RCSP_CNT_W = 16;

  // Transfer phases.
  typedef enum logic [1:0] {
    RCSP_ST_DIR = 2'b00,
    RCSP_ST_ADDR = 2'b01,
    RCSP_ST_DATA = 2'b10
  } rcsp_state_t;

  // Serial pins as sampled by the block clock.
  typedef struct packed {
    logic select;
    logic sclk;
    logic sdata;
  } rcsp_pins_t;

  // Radio control outputs.
  typedef struct packed {
    logic [7:0] first_config_register;
    logic [7:0] second_config_register;
    logic [7:0] third_config_register;
    logic serial_control;
    logic active_mode;
  } rcsp_ctrl_t;

endpackage

// ===== verification/rcsp_asserts.sv
// Checker for the configuration serial port.
`timescale 1ns/1ps
module rcsp_asserts
  import rcsp_pkg::*;
#(
  parameter int RECOV_HALF_CYC = RCSP_RECOV_HALF_CYC
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Watched ports.
  input wire logic select_pin,
  input wire logic config_serial_clock,
  input wire logic config_serial_data_out,
  input wire logic config_serial_data_oe,
  input wire logic recovered_bit_clock,
  input wire rcsp_ctrl_t ctrl
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  int hi_cnt_r;
  // Length of each high phase, so that a half period can be judged.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hi_cnt_r <= 0;
    end else begin
      hi_cnt_r <= recovered_bit_clock ? hi_cnt_r + 1 : 0;
    end
  end
  sequence s_sel_up;
    $rose(select_pin);
  endsequence
  chk_mode_entry: assert property (s_sel_up |-> ##[1:5] ctrl.serial_control)
    else $error("serial control not entered");
  chk_mode_sticky: assert property (ctrl.serial_control |=> ctrl.serial_control)
    else $error("serial control lost");
  chk_select_wakes: assert property (s_sel_up |-> ##[1:5] ctrl.active_mode)
    else $error("select did not wake");
  chk_oe_release: assert property ($fell(select_pin) |-> ##[1:5] !config_serial_data_oe)
    else $error("data line not released");
  chk_data_launch: assert property ($changed(config_serial_data_out) && config_serial_data_oe
    |-> config_serial_clock)
    else $error("read bit changed outside clock high");
  chk_reg_select: assert property ($changed(ctrl.second_config_register) |-> select_pin)
    else $error("register written without select");
  chk_bitclk_idle: assert property (!ctrl.first_config_register[0] [*3] |->
    !recovered_bit_clock)
    else $error("bit clock runs while disabled");
  chk_bitclk_half: assert property ($fell(recovered_bit_clock) && ctrl.first_config_register[0]
    |-> hi_cnt_r == RECOV_HALF_CYC)
    else $error("bit clock half period wrong");
endmodule

// ===== verification/rcsp_host.sv
// Host model driving the three configuration lines.
`timescale 1ns/1ps
module rcsp_host (
  // Clock.
  input wire logic clock,
  // Serial lines.
  output logic select_pin,
  output logic sclk,
  output logic sdata,
  input wire logic line
);
  // Lines start low; select and the serial clock stay low between frames, data is left inverted.
  initial begin
    select_pin = 1'b0;
    sclk = 1'b0;
    sdata = 1'b0;
  end
  // One bit of 25 cycles; read data is taken as the clock falls.
  task automatic shift(input logic b, output logic s);
    repeat (7) @(posedge clock);
    sdata <= b;
    repeat (6) @(posedge clock);
    sclk <= 1'b1;
    repeat (12) @(posedge clock);
    s = line;
    sclk <= 1'b0;
  endtask
  // Direction, address, then n bytes less cut bits; q keeps the last eight data bits seen.
  task automatic xfer(input logic rd, input logic [1:0] a, input int n,
                      input logic [23:0] wd, input int cut, output logic [7:0] q);
    logic s;
    @(posedge clock);
    select_pin <= 1'b1;
    repeat (20) @(posedge clock);
    shift(rd, s);
    shift(a[1], s);
    shift(a[0], s);
    for (int k = 0; k < 8 * n - cut; k++) begin
      shift(wd[23 - k], s);
      q = {q[6:0], s};
    end
    repeat (20) @(posedge clock);
    select_pin <= 1'b0;
    sdata <= ~sdata;
    repeat (20) @(posedge clock);
  endtask
endmodule

// ===== verification/testbench.sv
// Testbench for the configuration serial port.
`timescale 1ns/1ps
module testbench import rcsp_pkg::*;;
  logic clock, resetn, start_symbol, sel, sclk, hdata, dout, doe, rbc;
  wire line = doe ? dout : hdata;
  rcsp_ctrl_t ctrl;
  logic [7:0] q;
  logic [15:0] v;
  int mismatches, comparisons, n;
  rcsp_port #(.RECOV_HALF_CYC(4)) DUT (.clock(clock), .resetn(resetn), .clk_en(1'b1),
    .select_pin(sel), .config_serial_clock(sclk), .config_serial_data_in(line),
    .config_serial_data_out(dout), .config_serial_data_oe(doe),
    .start_symbol(start_symbol), .recovered_bit_clock(rbc), .ctrl(ctrl));
  rcsp_host host (.clock(clock), .select_pin(sel), .sclk(sclk), .sdata(hdata), .line(line));
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Each command pair as one burst from address zero, then the second register read back.
  task automatic t_cmds;
    logic [15:0] tbl [4] = '{16'h0000, 16'h0104, 16'h4020, 16'h8000};
    for (int k = 0; k < 4; k++) begin
      host.xfer(RCSP_DIR_WRITE, RCSP_ADDR_FIRST, 2, {tbl[k], 8'h00}, 0, q);
      cmp(ctrl.first_config_register, tbl[k][15:8]);
      cmp(ctrl.second_config_register, tbl[k][7:0]);
      if (k == 3) cmp({7'h00, ctrl.active_mode}, 8'h00);
      host.xfer(RCSP_DIR_READ, RCSP_ADDR_SECOND, 1, 24'h0, 0, q);
      cmp(q, tbl[k][7:0]);
    end
    cmp({7'h00, ctrl.active_mode}, 8'h01);
  endtask
  // A short byte is dropped; a burst from the last address wraps to zero.
  task automatic t_wrap;
    host.xfer(RCSP_DIR_WRITE, RCSP_ADDR_SECOND, 1, 24'hFF0000, 3, q);
    cmp(ctrl.second_config_register, 8'h00);
    host.xfer(RCSP_DIR_WRITE, RCSP_ADDR_LAST, 2, 24'hA53C00, 0, q);
    cmp(ctrl.third_config_register, 8'hA5);
    cmp(ctrl.first_config_register, 8'h3C);
  endtask
  // Bit clock starts on a start symbol and stops when recovery is cleared.
  task automatic t_recov;
    host.xfer(RCSP_DIR_WRITE, RCSP_ADDR_FIRST, 1, 24'h010000, 0, q);
    @(posedge clock);
    start_symbol <= 1'b1;
    @(posedge clock);
    start_symbol <= 1'b0;
    for (n = 0; n < 50 && rbc !== 1'b1; n++) @(negedge clock);
    cmp({7'h00, rbc}, 8'h01);
    for (n = 0; n < 16; n++) begin
      v = {v[14:0], rbc};
      @(negedge clock);
    end
    cmp(v[15:8], 8'hF0);
    cmp(v[7:0], 8'hF0);
    host.xfer(RCSP_DIR_WRITE, RCSP_ADDR_FIRST, 1, 24'h0, 0, q);
    // Any high sample over ten cycles, two and a half half periods, means the clock did not stop.
    v = 16'h0000;
    repeat (10) begin
      @(negedge clock);
      v[0] = v[0] | rbc;
    end
    cmp({7'h00, v[0]}, 8'h00);
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    resetn = 1'b0;
    start_symbol = 1'b0;
    mismatches = 0;
    comparisons = 0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    cmp({7'h00, ctrl.serial_control}, 8'h00);
    t_cmds();
    t_wrap();
    t_recov();
    cmp({7'h00, ctrl.serial_control}, 8'h01);
    wrap_up();
  end
  // Watchdog: the tests need well under a tenth of this span.
  initial begin
    #400000;
    mismatches++;
    wrap_up();
  end
endmodule
bind rcsp_port rcsp_asserts #(.RECOV_HALF_CYC(RECOV_HALF_CYC)) u_chk (.clock(clock),
  .resetn(resetn), .select_pin(select_pin), .config_serial_clock(config_serial_clock),
  .config_serial_data_out(config_serial_data_out), .config_serial_data_oe(config_serial_data_oe),
  .recovered_bit_clock(recovered_bit_clock), .ctrl(ctrl));
